/* rtl/rfa_consts.vh */
// rfa_consts.vh: offsets, field codes and reset values for the register field cells.
// assumes: included by bare name from every design file of the block.
`ifndef RFA_CONSTS_VH
`define RFA_CONSTS_VH

// ==========================================================================
// field access kinds
// ==========================================================================
`define RFA_KIND_W       3
`define RFA_KIND_RW      3'h0
`define RFA_KIND_RO      3'h1
`define RFA_KIND_RC      3'h2
`define RFA_KIND_RWC     3'h3
`define RFA_KIND_RW1C    3'h4
`define RFA_KIND_RW1S    3'h5
`define RFA_KIND_W1C     3'h6
`define RFA_KIND_WO      3'h7

// ==========================================================================
// register window offsets (added to the base address)
// ==========================================================================
`define RFA_OFS_CTRL     12'h000
`define RFA_OFS_STATUS   12'h004
`define RFA_OFS_RIS      12'h008
`define RFA_OFS_ICR      12'h00C
`define RFA_OFS_COUNT    12'h010
`define RFA_OFS_SET      12'h014
`define RFA_OFS_CAPT     12'h018
`define RFA_OFS_CMD      12'h01C

// ==========================================================================
// field positions and reset values
// ==========================================================================
`define RFA_CTRL_MODE_HI 15
`define RFA_CTRL_MODE_LO 8
`define RFA_CTRL_EN_BIT  0
`define RFA_CTRL_RESET   32'h00000000
`define RFA_CTRL_MASK    32'h0000FF01
`define RFA_STATUS_RESET 32'h00000000
`define RFA_ZERO32       32'h00000000
`define RFA_ADDR_W       12

`endif

/* rtl/rfa_decoder.v */
// rfa_decoder.v: turns a bus address into one-hot register selects.
// assumes: base and offsets are word aligned; address comes from same-clock logic.
`timescale 1ns/1ps
`include "rfa_consts.vh"

module rfa_decoder #(
  parameter [31:0]  BASE = 32'h40000000
) (
  input  wire [31:0] address,
  output reg  [7:0]  select,
  output reg         hit
);

  wire [31:0] offset = address - BASE;

  always @* begin
    select = 8'h00;
    hit    = 1'b0;
    if (offset[31:`RFA_ADDR_W] != 20'h00000) begin
      hit = 1'b0;
    end else if (offset[`RFA_ADDR_W-1:0] == `RFA_OFS_CTRL) begin
      select = 8'h01;
    end else if (offset[`RFA_ADDR_W-1:0] == `RFA_OFS_STATUS) begin
      select = 8'h02;
    end else if (offset[`RFA_ADDR_W-1:0] == `RFA_OFS_RIS) begin
      select = 8'h04;
    end else if (offset[`RFA_ADDR_W-1:0] == `RFA_OFS_ICR) begin
      select = 8'h08;
    end else if (offset[`RFA_ADDR_W-1:0] == `RFA_OFS_COUNT) begin
      select = 8'h10;
    end else if (offset[`RFA_ADDR_W-1:0] == `RFA_OFS_SET) begin
      select = 8'h20;
    end else if (offset[`RFA_ADDR_W-1:0] == `RFA_OFS_CAPT) begin
      select = 8'h40;
    end else if (offset[`RFA_ADDR_W-1:0] == `RFA_OFS_CMD) begin
      select = 8'h80;
    end
    if (select != 8'h00) hit = 1'b1;
  end

endmodule // rfa_decoder

/* rtl/rfa_field_cell.v */
// rfa_field_cell.v: one register field of configurable access kind and width.
// assumes: write and read strobes are single-cycle, from logic on the same clock.
`timescale 1ns/1ps
`include "rfa_consts.vh"

module rfa_field_cell #(
  parameter                     WIDTH      = 8,
  parameter [`RFA_KIND_W-1:0]   KIND       = `RFA_KIND_RW,
  parameter [31:0]              RESET_VAL  = 32'h00000000,
  parameter [31:0]              RESET_DEF  = 32'hFFFFFFFF
) (
  input  wire                   clock,
  input  wire                   reset_n,
  input  wire                   write_strobe,
  input  wire                   read_strobe,
  input  wire [WIDTH-1:0]       write_data,
  input  wire [WIDTH-1:0]       hw_set,
  input  wire                   hw_load,
  input  wire [WIDTH-1:0]       hw_data,
  output wire [WIDTH-1:0]       value,
  output wire [WIDTH-1:0]       read_data,
  output wire [WIDTH-1:0]       write_pulse
);

  // ==========================================================================
  // per-bit storage
  // ==========================================================================
  reg  [WIDTH-1:0] field;
  reg  [WIDTH-1:0] pulse;
  reg  [WIDTH-1:0] next_field;
  reg  [WIDTH-1:0] next_pulse;
  wire [WIDTH-1:0] reset_val = RESET_VAL[WIDTH-1:0];
  wire [WIDTH-1:0] reset_def = RESET_DEF[WIDTH-1:0];

  genvar b;
  generate
    for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
      always @* begin
        next_field[b] = field[b];
        next_pulse[b] = 1'b0;
        case (KIND)
          `RFA_KIND_RW: begin
            if (write_strobe) next_field[b] = write_data[b];
          end
          `RFA_KIND_RO: begin
            next_field[b] = hw_load ? hw_data[b] : field[b];
          end
          `RFA_KIND_RC: begin
            if (read_strobe) next_field[b] = 1'b0;
            if (hw_set[b]) next_field[b] = 1'b1;
          end
          `RFA_KIND_RWC: begin
            if (write_strobe) next_field[b] = 1'b0;
            if (hw_set[b]) next_field[b] = 1'b1;
          end
          `RFA_KIND_RW1C: begin
            if (write_strobe && write_data[b]) next_field[b] = 1'b0;
            if (hw_set[b]) next_field[b] = 1'b1;
          end
          `RFA_KIND_RW1S: begin
            if (write_strobe && write_data[b]) next_field[b] = 1'b1;
          end
          default: begin
            // write-only kinds keep no state and emit a write pulse
            next_field[b] = 1'b0;
            if (write_strobe) next_pulse[b] = write_data[b];
          end
        endcase
      end

      // a dash bit leaves reset alone and comes up as it will
      always @(posedge clock) begin
        if (!reset_n && reset_def[b]) begin
          field[b] <= reset_val[b];
        end else begin
          field[b] <= next_field[b];
        end
      end

      always @(posedge clock) begin
        if (!reset_n) begin
          pulse[b] <= 1'b0;
        end else begin
          pulse[b] <= next_pulse[b];
        end
      end
    end
  endgenerate

  assign value       = field;
  assign write_pulse = pulse;
  assign read_data   = ((KIND == `RFA_KIND_WO) || (KIND == `RFA_KIND_W1C)) ?
                       {WIDTH{1'b0}} : field;

endmodule // rfa_field_cell

/* rtl/rfa_register_bank.v */
// rfa_register_bank.v: a bank of eight registers, one per field access kind.
// assumes: a single-cycle register port driven by logic on the same clock;
// hardware event and load inputs also come from that clock domain.
//
// Operation
// - read-clear field returns its value then clears on the read
// - read-write field stores written data and returns it on read
// - write-any-clear register is readable; any write clears it
// - write-one-clear: a one clears that bit only, zero leaves it
// - readable status bits cleared exactly by writing back the read value
// - write-one-set: a one sets the bit, zero leaves it, readable
// - write-only clear register clears bits of the associated status register
// - write-only register acts on writes; reads carry no meaning
// - reserved bits read as zero; software preserves them
// - each field takes its reset value; dash bits are left unset
// - registers decode at their offset added to the base address
// - a field upper:lower spans every bit between them inclusive
`timescale 1ns/1ps
`include "rfa_consts.vh"

module rfa_register_bank #(
  parameter [31:0]  BASE      = 32'h40000000,
  parameter         EVENT_W   = 8,
  parameter [31:0]  CAPT_DEF  = 32'h0000FFFF
) (
  input  wire                clock,
  input  wire                reset_n,
  input  wire                reg_select,
  input  wire                reg_write,
  input  wire [31:0]         reg_address,
  input  wire [31:0]         reg_write_data,
  output reg  [31:0]         reg_read_data,
  output reg                 reg_ready,
  output reg                 reg_error,
  input  wire [EVENT_W-1:0]  event_in,
  input  wire [EVENT_W-1:0]  error_event,
  input  wire [EVENT_W-1:0]  count_event,
  input  wire                state_load,
  input  wire [15:0]         state_data,
  output reg                 enable,
  output reg  [7:0]          mode,
  output reg  [EVENT_W-1:0]  pending,
  output reg  [EVENT_W-1:0]  latched,
  output reg  [EVENT_W-1:0]  command
);

  // ==========================================================================
  // access strobes
  // ==========================================================================
  wire [7:0] select;
  wire       hit;
  wire       access = reg_select && !reg_ready;
  wire       wr     = access && reg_write;
  wire       rd     = access && !reg_write;

  rfa_decoder #(
    .BASE    (BASE)
  ) u_decoder (
    .address (reg_address),
    .select  (select),
    .hit     (hit)
  );

  // ==========================================================================
  // control: read-write mode and enable fields
  // ==========================================================================
  wire [7:0] mode_value;
  wire [0:0] en_value;

  rfa_field_cell #(
    .WIDTH       (`RFA_CTRL_MODE_HI - `RFA_CTRL_MODE_LO + 1),
    .KIND        (`RFA_KIND_RW),
    .RESET_VAL   (`RFA_CTRL_RESET)
  ) u_mode (
    .clock       (clock),
    .reset_n     (reset_n),
    .write_strobe(wr && select[0]),
    .read_strobe (1'b0),
    .write_data  (reg_write_data[`RFA_CTRL_MODE_HI:`RFA_CTRL_MODE_LO]),
    .hw_set      (8'h00),
    .hw_load     (1'b0),
    .hw_data     (8'h00),
    .value       (mode_value),
    .read_data   (),
    .write_pulse ()
  );

  rfa_field_cell #(
    .WIDTH       (1),
    .KIND        (`RFA_KIND_RW),
    .RESET_VAL   (`RFA_CTRL_RESET)
  ) u_enable (
    .clock       (clock),
    .reset_n     (reset_n),
    .write_strobe(wr && select[0]),
    .read_strobe (1'b0),
    .write_data  (reg_write_data[`RFA_CTRL_EN_BIT]),
    .hw_set      (1'b0),
    .hw_load     (1'b0),
    .hw_data     (1'b0),
    .value       (en_value),
    .read_data   (),
    .write_pulse ()
  );

  // ==========================================================================
  // status: read-only, loaded by hardware
  // ==========================================================================
  wire [15:0] status_value;

  rfa_field_cell #(
    .WIDTH       (16),
    .KIND        (`RFA_KIND_RO),
    .RESET_VAL   (`RFA_STATUS_RESET)
  ) u_status (
    .clock       (clock),
    .reset_n     (reset_n),
    .write_strobe(wr && select[1]),
    .read_strobe (1'b0),
    .write_data  (reg_write_data[15:0]),
    .hw_set      (16'h0000),
    .hw_load     (state_load),
    .hw_data     (state_data),
    .value       (status_value),
    .read_data   (),
    .write_pulse ()
  );

  // ==========================================================================
  // raw interrupt status (write-one-clear) and its write-only clear register
  // ==========================================================================
  wire [EVENT_W-1:0] ris_value;
  wire [EVENT_W-1:0] icr_pulse;
  wire               ris_clear = (wr && select[2]) || (|icr_pulse);
  wire [EVENT_W-1:0] ris_data  = (wr && select[2]) ? reg_write_data[EVENT_W-1:0]
                                                   : icr_pulse;

  rfa_field_cell #(
    .WIDTH       (EVENT_W),
    .KIND        (`RFA_KIND_RW1C),
    .RESET_VAL   (`RFA_ZERO32)
  ) u_ris (
    .clock       (clock),
    .reset_n     (reset_n),
    .write_strobe(ris_clear),
    .read_strobe (1'b0),
    .write_data  (ris_data),
    .hw_set      (event_in),
    .hw_load     (1'b0),
    .hw_data     ({EVENT_W{1'b0}}),
    .value       (ris_value),
    .read_data   (),
    .write_pulse ()
  );

  rfa_field_cell #(
    .WIDTH       (EVENT_W),
    .KIND        (`RFA_KIND_W1C),
    .RESET_VAL   (`RFA_ZERO32)
  ) u_icr (
    .clock       (clock),
    .reset_n     (reset_n),
    .write_strobe(wr && select[3]),
    .read_strobe (1'b0),
    .write_data  (reg_write_data[EVENT_W-1:0]),
    .hw_set      ({EVENT_W{1'b0}}),
    .hw_load     (1'b0),
    .hw_data     ({EVENT_W{1'b0}}),
    .value       (),
    .read_data   (),
    .write_pulse (icr_pulse)
  );

  // ==========================================================================
  // event log (write-any-clear), set register, read-clear capture, command
  // ==========================================================================
  wire [EVENT_W-1:0] count_value;
  wire [EVENT_W-1:0] set_value;
  wire [15:0]        capt_value;
  wire [EVENT_W-1:0] cmd_pulse;

  rfa_field_cell #(
    .WIDTH       (EVENT_W),
    .KIND        (`RFA_KIND_RWC),
    .RESET_VAL   (`RFA_ZERO32)
  ) u_count (
    .clock       (clock),
    .reset_n     (reset_n),
    .write_strobe(wr && select[4]),
    .read_strobe (1'b0),
    .write_data  (reg_write_data[EVENT_W-1:0]),
    .hw_set      (count_event),
    .hw_load     (1'b0),
    .hw_data     ({EVENT_W{1'b0}}),
    .value       (count_value),
    .read_data   (),
    .write_pulse ()
  );

  rfa_field_cell #(
    .WIDTH       (EVENT_W),
    .KIND        (`RFA_KIND_RW1S),
    .RESET_VAL   (`RFA_ZERO32)
  ) u_set (
    .clock       (clock),
    .reset_n     (reset_n),
    .write_strobe(wr && select[5]),
    .read_strobe (1'b0),
    .write_data  (reg_write_data[EVENT_W-1:0]),
    .hw_set      ({EVENT_W{1'b0}}),
    .hw_load     (1'b0),
    .hw_data     ({EVENT_W{1'b0}}),
    .value       (set_value),
    .read_data   (),
    .write_pulse ()
  );

  // bits left clear in CAPT_DEF are dash bits: no reset value
  rfa_field_cell #(
    .WIDTH       (16),
    .KIND        (`RFA_KIND_RC),
    .RESET_VAL   (`RFA_ZERO32),
    .RESET_DEF   (CAPT_DEF)
  ) u_capt (
    .clock       (clock),
    .reset_n     (reset_n),
    .write_strobe(wr && select[6]),
    .read_strobe (rd && select[6]),
    .write_data  (reg_write_data[15:0]),
    .hw_set      ({{(16-EVENT_W){1'b0}}, error_event}),
    .hw_load     (1'b0),
    .hw_data     (16'h0000),
    .value       (capt_value),
    .read_data   (),
    .write_pulse ()
  );

  rfa_field_cell #(
    .WIDTH       (EVENT_W),
    .KIND        (`RFA_KIND_WO),
    .RESET_VAL   (`RFA_ZERO32)
  ) u_cmd (
    .clock       (clock),
    .reset_n     (reset_n),
    .write_strobe(wr && select[7]),
    .read_strobe (1'b0),
    .write_data  (reg_write_data[EVENT_W-1:0]),
    .hw_set      ({EVENT_W{1'b0}}),
    .hw_load     (1'b0),
    .hw_data     ({EVENT_W{1'b0}}),
    .value       (),
    .read_data   (),
    .write_pulse (cmd_pulse)
  );

  // ==========================================================================
  // read mux: reserved bits and write-only registers read zero
  // ==========================================================================
  reg [31:0] next_read_data;

  always @* begin
    next_read_data = `RFA_ZERO32;
    if (select[0]) begin
      next_read_data[`RFA_CTRL_MODE_HI:`RFA_CTRL_MODE_LO] = mode_value;
      next_read_data[`RFA_CTRL_EN_BIT] = en_value[0];
    end else if (select[1]) begin
      next_read_data[15:0] = status_value;
    end else if (select[2]) begin
      next_read_data[EVENT_W-1:0] = ris_value;
    end else if (select[4]) begin
      next_read_data[EVENT_W-1:0] = count_value;
    end else if (select[5]) begin
      next_read_data[EVENT_W-1:0] = set_value;
    end else if (select[6]) begin
      next_read_data[15:0] = capt_value;
    end
  end

  // ==========================================================================
  // port answer and registered outputs
  // ==========================================================================
  always @(posedge clock) begin
    if (!reset_n) begin
      reg_read_data <= `RFA_ZERO32;
      reg_ready     <= 1'b0;
      reg_error     <= 1'b0;
      enable        <= 1'b0;
      mode          <= 8'h00;
      pending       <= {EVENT_W{1'b0}};
      latched       <= {EVENT_W{1'b0}};
      command       <= {EVENT_W{1'b0}};
    end else begin
      reg_ready     <= access;
      reg_error     <= access && !hit;
      if (rd) reg_read_data <= next_read_data;
      enable        <= en_value[0];
      mode          <= mode_value;
      pending       <= ris_value & {EVENT_W{en_value[0]}};
      latched       <= set_value;
      command       <= cmd_pulse;
    end
  end

endmodule // rfa_register_bank

/* tb/rfa_bus_master.sv */
// rfa_bus_master.sv: register port master issuing reads and writes.
// assumes: the bank answers with a one-cycle ready on the same clock.
`timescale 1ns/1ps
module rfa_bus_master #(
  parameter [31:0] BASE = 32'h40000000
) (
  input  wire        clock,
  output reg         reg_select,
  output reg         reg_write,
  output reg  [31:0] reg_address,
  output reg  [31:0] reg_write_data,
  input  wire [31:0] reg_read_data,
  input  wire        reg_ready,
  input  wire        reg_error
);
  initial begin
    reg_select = 1'b0;
    reg_write = 1'b0;
    reg_address = 32'h0;
    reg_write_data = 32'h0;
  end
  // request held until ready is sampled; released lines show inverted values
  task xfer(input w, input [31:0] o, input [31:0] d, output [31:0] q, output e,
            output ok);
    integer i;
    begin
      @(posedge clock);
      reg_select <= 1'b1;
      reg_write <= w;
      reg_address <= BASE + o;
      reg_write_data <= d;
      i = 0;
      do begin
        @(posedge clock);
        i = i + 1;
      end while (reg_ready !== 1'b1 && i < 9);
      ok = (reg_ready === 1'b1);
      q = reg_read_data;
      e = reg_error;
      reg_select <= 1'b0;
      reg_address <= ~reg_address;
      reg_write_data <= ~reg_write_data;
    end
  endtask
endmodule // rfa_bus_master

/* tb/rfa_register_bank_sva.sv */
// rfa_register_bank_sva.sv: port assertions for the register bank.
// assumes: bound into rfa_register_bank; one clock, synchronous reset.
`timescale 1ns/1ps
module rfa_register_bank_sva #(
  parameter [31:0] BASE     = 32'h40000000,
  parameter        EVENT_W  = 8,
  parameter [31:0] CAPT_DEF = 32'h0000FFFF
) (
  input wire               clock,
  input wire               reset_n,
  input wire               reg_select,
  input wire               reg_write,
  input wire [31:0]        reg_address,
  input wire [31:0]        reg_write_data,
  input wire [31:0]        reg_read_data,
  input wire               reg_ready,
  input wire               reg_error,
  input wire [EVENT_W-1:0] event_in,
  input wire [EVENT_W-1:0] error_event,
  input wire [EVENT_W-1:0] count_event,
  input wire               state_load,
  input wire [15:0]        state_data,
  input wire               enable,
  input wire [7:0]         mode,
  input wire [EVENT_W-1:0] pending,
  input wire [EVENT_W-1:0] latched,
  input wire [EVENT_W-1:0] command
);
  // ==========================================================================
  // access decode
  wire               take  = reg_select && !reg_ready;
  wire               wr    = take && reg_write;
  wire               rd    = take && !reg_write;
  wire [31:0]        ofs   = reg_address - BASE;
  wire               wen   = reg_write_data[0];
  wire [7:0]         wmode = reg_write_data[15:8];
  wire [EVENT_W-1:0] wev   = reg_write_data[EVENT_W-1:0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // properties
  property p_answer;
    take |=> reg_ready ##1 !reg_ready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("access not answered by a one-cycle ready");
  property p_unmapped;
    rd && ofs >= 32'h20 |=> reg_error && reg_read_data == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not flagged or not zero");
  property p_mapped;
    take && ofs < 32'h20 && ofs[1:0] == 2'b00 |=> reg_ready && !reg_error;
  endproperty
  a_mapped: assert property (p_mapped)
    else $error("mapped access flagged as error");
  property p_ctrl;
    wr && ofs == 32'h0 |-> ##2 (enable == $past(wen, 2) && mode == $past(wmode, 2));
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control outputs do not follow the written word");
  property p_latched;
    wr && ofs == 32'h14 |-> ##2 latched == ($past(latched, 2) | $past(wev, 2));
  endproperty
  a_latched: assert property (p_latched)
    else $error("set register did not or-in the written ones");
  property p_cmd;
    wr && ofs == 32'h1C |-> ##2 command == $past(wev, 2) ##1 command == {EVENT_W{1'b0}};
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("command pulse wrong value or length");
  property p_wo_zero;
    rd && (ofs == 32'hC || ofs == 32'h1C) |=> reg_read_data == 32'h0;
  endproperty
  a_wo_zero: assert property (p_wo_zero)
    else $error("write-only register read not zero");
  property p_reserved;
    rd && ofs == 32'h0 |=> reg_read_data[31:16] == 16'h0 && reg_read_data[7:1] == 7'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits read nonzero");
  property p_pending;
    !enable && !$past(enable) |-> pending == {EVENT_W{1'b0}};
  endproperty
  a_pending: assert property (p_pending)
    else $error("pending shown while disabled");
  c_cmd: cover property (wr && ofs == 32'h1C);
  c_unmapped: cover property (rd && ofs >= 32'h20);
  c_capt: cover property (rd && ofs == 32'h18 ##1 reg_read_data[7:0] != 8'h00);
endmodule // rfa_register_bank_sva

bind rfa_register_bank rfa_register_bank_sva #(
  .BASE(BASE), .EVENT_W(EVENT_W), .CAPT_DEF(CAPT_DEF)) u_sva (
  .clock(clock), .reset_n(reset_n), .reg_select(reg_select), .reg_write(reg_write),
  .reg_address(reg_address), .reg_write_data(reg_write_data),
  .reg_read_data(reg_read_data), .reg_ready(reg_ready), .reg_error(reg_error),
  .event_in(event_in), .error_event(error_event), .count_event(count_event),
  .state_load(state_load), .state_data(state_data), .enable(enable), .mode(mode),
  .pending(pending), .latched(latched), .command(command));

/* tb/rfa_register_bank_test.sv */
// rfa_register_bank_test.sv: self-checking bench with a behavioural model.
// assumes: rfa_bus_master drives the port; the checker is bound separately.
`timescale 1ns/1ps
`define CHK(a, b) begin checked = checked + 1; if ((a) !== (b)) begin \
  n_errors = n_errors + 1; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module rfa_register_bank_test;
  localparam [31:0] BASE = 32'h40000000;
  reg         clock, reset_n, state_load;
  reg  [7:0]  event_in, error_event, count_event;
  reg  [15:0] state_data;
  wire        sel, wr, rdy, err, enable;
  wire [31:0] adr, wd, rdd;
  wire [7:0]  mode, pending, latched, command;
  integer     n_errors, checked, seed, k, j, r;
  reg  [31:0] m_ctrl, m_stat, m_ris, m_log, m_set, m_capt, d;
  reg  [31:0] ofs [0:10];

  rfa_register_bank #(.BASE(BASE), .EVENT_W(8), .CAPT_DEF(32'h000000FF)) DUT (
    .clock(clock), .reset_n(reset_n), .reg_select(sel), .reg_write(wr),
    .reg_address(adr), .reg_write_data(wd), .reg_read_data(rdd), .reg_ready(rdy),
    .reg_error(err), .event_in(event_in), .error_event(error_event),
    .count_event(count_event), .state_load(state_load), .state_data(state_data),
    .enable(enable), .mode(mode), .pending(pending), .latched(latched),
    .command(command));
  rfa_bus_master #(.BASE(BASE)) m (
    .clock(clock), .reg_select(sel), .reg_write(wr), .reg_address(adr),
    .reg_write_data(wd), .reg_read_data(rdd), .reg_ready(rdy), .reg_error(err));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // ==========================================================================
  // tasks
  task stop_test;
    begin
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task rst_model;
    begin
      {m_ctrl, m_stat, m_ris, m_log, m_set, m_capt} = {6{32'h0}};
    end
  endtask
  task ev(input [7:0] i, input [7:0] c, input [7:0] g, input [15:0] s, input ld);
    begin
      @(posedge clock);
      event_in <= i;
      count_event <= c;
      error_event <= g;
      state_load <= ld;
      state_data <= s;
      @(posedge clock);
      {event_in, count_event, error_event, state_load} <= 25'h0;
      state_data <= ~s;
      m_ris = m_ris | i;
      m_log = m_log | c;
      m_capt = m_capt | g;
      if (ld) m_stat = s;
    end
  endtask
  task acc(input w, input [31:0] o, input [31:0] dat);
    reg [31:0] q, x, mk;
    reg        e, ok, xe;
    begin
      m.xfer(w, o, dat, q, e, ok);
      xe = (o >= 32'h20);
      x = 32'h0;
      mk = (o == 32'h18) ? 32'hFFFF00FF : 32'hFFFFFFFF;
      if (w) case (o)
        32'h0: m_ctrl = dat & 32'h0000FF01;
        32'h8, 32'hC: m_ris = m_ris & ~dat;
        32'h10: m_log = 32'h0;
        32'h14: m_set = m_set | dat[7:0];
        default: x = 32'h0;
      endcase
      else case (o)
        32'h0: x = m_ctrl;
        32'h4: x = m_stat;
        32'h8: x = m_ris;
        32'h10: x = m_log;
        32'h14: x = m_set;
        32'h18: begin
          x = m_capt;
          m_capt = 32'h0;
        end
        default: x = 32'h0;
      endcase
      if (!ok) begin
        n_errors = n_errors + 1;
        stop_test;
      end
      `CHK(e, xe)
      if (!w) `CHK(q & mk, x & mk)
    end
  endtask
  task read_all;
    begin
      for (j = 0; j < 11; j = j + 1) acc(1'b0, ofs[j], 32'h0);
    end
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    seed = 32'h208e;
    n_errors = 0;
    checked = 0;
    reset_n = 1'b0;
    {event_in, error_event, count_event, state_load, state_data} = 41'h0;
    rst_model;
    for (k = 0; k < 8; k = k + 1) ofs[k] = 4 * k;
    ofs[8] = 32'h20;
    ofs[9] = 32'hFFC;
    ofs[10] = 32'h1000;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    read_all;
    $display("test reset_values done");
    for (r = 0; r < 4; r = r + 1) begin
      d = $random(seed);
      ev(d[7:0], d[15:8], d[23:16], d[31:16], 1'b1);
      for (k = 0; k < 11; k = k + 1) begin
        d = $random(seed);
        // status is written with its reset value
        if (k == 1) d = 32'h0;
        acc(1'b1, ofs[k], d);
        @(negedge clock);
        if (k == 0) `CHK(({mode, enable}), ({d[15:8], d[0]}))
        if (k == 5) `CHK(latched, m_set[7:0])
        if (k == 7) `CHK(command, d[7:0])
      end
      read_all;
    end
    $display("test random_rounds done");
    acc(1'b1, 32'h8, 32'hFF);
    ev(8'h0F, 8'h00, 8'h00, 16'h0, 1'b0);
    acc(1'b0, 32'h8, 32'h0);
    d = m_ris;
    ev(8'hF0, 8'h00, 8'h00, 16'h0, 1'b0);
    acc(1'b1, 32'h8, d);
    acc(1'b0, 32'h8, 32'h0);
    acc(1'b1, 32'hC, 32'h30);
    acc(1'b0, 32'h8, 32'h0);
    $display("test w1c_readback done");
    @(posedge clock);
    event_in <= 8'h01;
    fork
      acc(1'b1, 32'h8, 32'hFF);
      begin
        @(posedge clock);
        @(posedge clock);
        event_in <= 8'h00;
      end
    join
    m_ris = 32'h1;
    acc(1'b0, 32'h8, 32'h0);
    @(posedge clock);
    error_event <= 8'h02;
    m_capt = m_capt | 32'h2;
    fork
      acc(1'b0, 32'h18, 32'h0);
      begin
        @(posedge clock);
        @(posedge clock);
        error_event <= 8'h00;
      end
    join
    m_capt = 32'h2;
    acc(1'b0, 32'h18, 32'h0);
    $display("test set_wins done");
    acc(1'b1, 32'h0, 32'h1);
    ev(8'h5A, 8'h00, 8'h00, 16'h0, 1'b0);
    repeat (2) @(negedge clock);
    `CHK(pending, m_ris[7:0])
    $display("test pending done");
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    rst_model;
    @(negedge clock);
    `CHK(({enable, mode, pending, latched}), 25'h0)
    read_all;
    $display("test second_reset done");
    stop_test;
  end
endmodule // rfa_register_bank_test
